// ### hdl/rlcis_pin_sel.v
// One timer clock-input selector: routes a remappable pin or ground to the timer.
// Assumes pins are already synchronous to sys_clk_in.
`timescale 1ns/10ps
`include "rlcis_map.vh"
module rlcis_pin_sel #(
	parameter NUM_PINS = `RLCIS_NUM_PINS
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire [4:0] code_in,
	input wire [NUM_PINS-1:0] pins_in,
	output reg clk_out
);
	reg next_clk;
	always @* begin
		next_clk = 1'b0;
		// Reserved codes and ground code both give a quiet low input
		if (code_in <= `RLCIS_SEL_MAX_PIN) begin
			next_clk = pins_in[code_in];
		end
	end
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_out <= 1'b0;
		end else if (clk_en_in) begin
			clk_out <= next_clk;
		end
	end
endmodule // rlcis_pin_sel

// ### hdl/rlcis_shadow.v
// Shadow copy of one remap register and its mismatch compare.
// Assumes the owner pulses load_in on every permitted write.
`timescale 1ns/10ps
module rlcis_shadow #(
	parameter WIDTH = 16
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire load_in,
	input wire [WIDTH-1:0] load_data_in,
	input wire [WIDTH-1:0] live_in,
	output wire mismatch_out
);
	reg [WIDTH-1:0] shadow;
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			shadow <= {WIDTH{1'b0}};
		end else if (clk_en_in && load_in) begin
			shadow <= load_data_in;
		end
	end
	// Compare runs every cycle, so a disturbed cell is seen at once
	assign mismatch_out = (shadow != live_in);
endmodule // rlcis_shadow

// ### hdl/rlcis_top.v
// Remap lock, key sequence, one-session lock, shadow monitor and timer clock input select.
// Assumes a one-cycle read/write strobe register port and synchronous pin inputs.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "rlcis_map.vh"
module rlcis_top #(
	parameter NUM_REMAP = `RLCIS_NUM_REMAP,
	parameter NUM_PINS = `RLCIS_NUM_PINS
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire single_session_cfg_in,
	input wire [`RLCIS_ADDR_W-1:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [NUM_PINS-1:0] remappable_pin_n_in,
	output reg [15:0] rdata_out,
	output reg remap_lock_out,
	output reg cfg_mismatch_reset_out,
	output reg [15:0] timer_clock_input_select_out,
	output wire timer5_ext_clock_out,
	output wire timer4_ext_clock_out,
	output reg [NUM_REMAP*16-1:0] remap_regs_out
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_KEY1 = 3'b010;
	localparam [2:0] ST_OPEN = 3'b100;

	reg [2:0] key_state;
	reg [2:0] next_key_state;
	reg remap_lock;
	reg next_remap_lock;
	reg one_session;
	reg strap_taken;
	reg [15:0] timer_clock_input_select;
	reg [15:0] remap_regs [0:NUM_REMAP-1];
	reg [7:0] osc_ctrl_low;
	reg mismatch_seen;
	wire wr_osc = wr_in && (addr_in == `RLCIS_OFF_OSC_CTRL);
	wire wr_sel = wr_in && (addr_in == `RLCIS_OFF_CLK_SEL);
	wire [NUM_REMAP-1:0] wr_remap;
	wire [NUM_REMAP:0] mismatch;
	wire [15:0] sel_masked = wdata_in & `RLCIS_CLK_SEL_MASK;
	wire sel_ok = wr_sel && !remap_lock;
	wire any_mismatch = |mismatch;
	integer i;

	// Strap caught after reset release, never inside the async branch
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			one_session <= 1'b1;
			strap_taken <= 1'b0;
		end else if (clk_en_in && !strap_taken) begin
			one_session <= single_session_cfg_in;
			strap_taken <= 1'b1;
		end
	end

	// Key sequence: any write to another register, or a wrong low byte other than the first key, drops it
	always @* begin
		next_key_state = key_state;
		next_remap_lock = remap_lock;
		if (wr_osc) begin
			case (key_state)
				ST_IDLE: begin
					if (wdata_in[7:0] == `RLCIS_KEY1) begin
						next_key_state = ST_KEY1;
					end
				end
				ST_KEY1: begin
					if (wdata_in[7:0] == `RLCIS_KEY2) begin
						next_key_state = ST_OPEN;
					end else if (wdata_in[7:0] == `RLCIS_KEY1) begin
						next_key_state = ST_KEY1;
					end else begin
						next_key_state = ST_IDLE;
					end
				end
				ST_OPEN: begin
					next_key_state = ST_IDLE;
					// Strap locked state cannot reopen until reset
					if (!(one_session && remap_lock)) begin
						next_remap_lock = wdata_in[`RLCIS_LOCK_BIT];
					end
				end
				default: begin
					next_key_state = ST_IDLE;
				end
			endcase
		end else if (wr_in && key_state != ST_IDLE) begin
			next_key_state = ST_IDLE;
		end
	end

	// Lock changes only through the sequence; no auto relock
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			key_state <= ST_IDLE;
			remap_lock <= 1'b0;
			osc_ctrl_low <= 8'h00;
		end else if (clk_en_in) begin
			key_state <= next_key_state;
			remap_lock <= next_remap_lock;
			if (wr_osc) begin
				osc_ctrl_low <= wdata_in[7:0];
			end
		end
	end

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_clock_input_select <= {3'h0, `RLCIS_SEL_RESET, 3'h0, `RLCIS_SEL_RESET};
		end else if (clk_en_in && sel_ok) begin
			timer_clock_input_select <= sel_masked;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_REMAP; g = g + 1) begin : g_remap
			localparam [`RLCIS_ADDR_W-1:0] REMAP_ADDR = `RLCIS_OFF_REMAP_BASE + g;
			assign wr_remap[g] = wr_in && (addr_in == REMAP_ADDR) && !remap_lock;
			always @(posedge sys_clk_in or posedge rst_in) begin
				if (rst_in) begin
					remap_regs[g] <= 16'h0000;
				end else if (clk_en_in && wr_remap[g]) begin
					remap_regs[g] <= wdata_in;
				end
			end
			rlcis_shadow #(.WIDTH(16)) u_shadow (
				.sys_clk_in(sys_clk_in),
				.rst_in(rst_in),
				.clk_en_in(clk_en_in),
				.load_in(wr_remap[g]),
				.load_data_in(wdata_in),
				.live_in(remap_regs[g]),
				.mismatch_out(mismatch[g])
			);
		end
	endgenerate

	// Select register shadow reset value matches the live reset value
	reg [15:0] sel_shadow;
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_shadow <= {3'h0, `RLCIS_SEL_RESET, 3'h0, `RLCIS_SEL_RESET};
		end else if (clk_en_in && sel_ok) begin
			sel_shadow <= sel_masked;
		end
	end
	assign mismatch[NUM_REMAP] = (sel_shadow != timer_clock_input_select);

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_mismatch_reset_out <= 1'b0;
			mismatch_seen <= 1'b0;
		end else if (clk_en_in) begin
			cfg_mismatch_reset_out <= any_mismatch;
			mismatch_seen <= mismatch_seen | any_mismatch;
		end
	end

	// Read port: data valid the cycle after the strobe, zero otherwise
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else if (clk_en_in) begin
			rdata_out <= 16'h0000;
			if (rd_in) begin
				if (addr_in == `RLCIS_OFF_OSC_CTRL) begin
					rdata_out <= {8'h00, osc_ctrl_low[7], remap_lock, osc_ctrl_low[5:0]};
				end else if (addr_in == `RLCIS_OFF_CLK_SEL) begin
					rdata_out <= timer_clock_input_select & `RLCIS_CLK_SEL_MASK;
				end else if (addr_in == `RLCIS_OFF_STATUS) begin
					rdata_out <= {11'h000, mismatch_seen, key_state, one_session};
				end else begin
					for (i = 0; i < NUM_REMAP; i = i + 1) begin
						if (addr_in == (i[`RLCIS_ADDR_W-1:0] + `RLCIS_OFF_REMAP_BASE)) begin
							rdata_out <= remap_regs[i];
						end
					end
				end
			end
		end
	end

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			remap_lock_out <= 1'b0;
			timer_clock_input_select_out <= {3'h0, `RLCIS_SEL_RESET, 3'h0, `RLCIS_SEL_RESET};
			remap_regs_out <= {NUM_REMAP*16{1'b0}};
		end else if (clk_en_in) begin
			remap_lock_out <= remap_lock;
			timer_clock_input_select_out <= timer_clock_input_select;
			for (i = 0; i < NUM_REMAP; i = i + 1) begin
				remap_regs_out[i*16 +: 16] <= remap_regs[i];
			end
		end
	end

	rlcis_pin_sel #(.NUM_PINS(NUM_PINS)) u_t5_sel (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.code_in(timer_clock_input_select[`RLCIS_T5_MSB:`RLCIS_T5_LSB]),
		.pins_in(remappable_pin_n_in),
		.clk_out(timer5_ext_clock_out)
	);

	rlcis_pin_sel #(.NUM_PINS(NUM_PINS)) u_t4_sel (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.code_in(timer_clock_input_select[`RLCIS_T4_MSB:`RLCIS_T4_LSB]),
		.pins_in(remappable_pin_n_in),
		.clk_out(timer4_ext_clock_out)
	);
endmodule // rlcis_top

// ### shared/rlcis_map.vh
// Register offsets, field positions, reset values and key bytes for the remap lock block.
// Assumes a 16-bit register port; offsets are word indices on that port.
`ifndef RLCIS_MAP_VH
`define RLCIS_MAP_VH

`define RLCIS_ADDR_W 4
`define RLCIS_OFF_OSC_CTRL 4'h0
`define RLCIS_OFF_CLK_SEL 4'h1
`define RLCIS_OFF_STATUS 4'h2
`define RLCIS_OFF_REMAP_BASE 4'h8
`define RLCIS_NUM_REMAP 4

`define RLCIS_LOCK_BIT 6
`define RLCIS_ONE_SESSION_BIT 5
`define RLCIS_KEY1 8'h46
`define RLCIS_KEY2 8'h57

`define RLCIS_T5_MSB 12
`define RLCIS_T5_LSB 8
`define RLCIS_T4_MSB 4
`define RLCIS_T4_LSB 0
`define RLCIS_SEL_RESET 5'h1F
`define RLCIS_SEL_GND 5'h1F
`define RLCIS_SEL_MAX_PIN 5'h19
`define RLCIS_CLK_SEL_MASK 16'h1F1F
`define RLCIS_NUM_PINS 26

`endif

// ### verif/rlcis_top_checker.sv
// Checker for the remap lock block: lock keys, write guard, selector routing.
// Assumes binding to rlcis_top, clock enable high and a strap steady outside reset.
`timescale 1ns/10ps
module rlcis_top_checker #(
	parameter NUM_REMAP = 4,
	parameter NUM_PINS = 26
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire single_session_cfg_in,
	input wire [3:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [NUM_PINS-1:0] remappable_pin_n_in,
	input wire [15:0] rdata_out,
	input wire remap_lock_out,
	input wire cfg_mismatch_reset_out,
	input wire [15:0] timer_clock_input_select_out,
	input wire timer5_ext_clock_out,
	input wire timer4_ext_clock_out,
	input wire [NUM_REMAP*16-1:0] remap_regs_out
);
	reg [NUM_PINS-1:0] pins_d;
	wire [4:0] s5 = timer_clock_input_select_out[12:8];
	wire [4:0] s4 = timer_clock_input_select_out[4:0];
	// Selector outputs lag the pins by one edge
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_d <= {NUM_PINS{1'b0}};
		end else begin
			pins_d <= remappable_pin_n_in;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	property p_locked_hold;
		remap_lock_out |=> $stable(remap_regs_out) && $stable(timer_clock_input_select_out);
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("remap write landed while locked");
	property p_lock_value;
		$changed(remap_lock_out) |-> remap_lock_out == $past(wdata_in[6], 2);
	endproperty
	a_lock_value: assert property (p_lock_value) else $error("lock differs from written bit");
	property p_key_seq;
		$changed(remap_lock_out) |-> $past(wdata_in[7:0], 3) == 8'h57 && $past(wdata_in[7:0], 4) == 8'h46;
	endproperty
	a_key_seq: assert property (p_key_seq) else $error("lock changed without keys");
	property p_lock_sticky;
		!$past(wr_in, 2) |-> $stable(remap_lock_out);
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock moved without a write");
	property p_no_mismatch;
		!cfg_mismatch_reset_out;
	endproperty
	a_no_mismatch: assert property (p_no_mismatch) else $error("mismatch reset in normal use");
	property p_one_session;
		single_session_cfg_in && $past(remap_lock_out) |-> remap_lock_out;
	endproperty
	a_one_session: assert property (p_one_session) else $error("lock cleared in one-session mode");
	property p_t5_route;
		timer5_ext_clock_out == ((s5 > 5'h19) ? 1'b0 : pins_d[s5]);
	endproperty
	a_t5_route: assert property (p_t5_route) else $error("timer5 clock routing wrong");
	property p_t4_route;
		timer4_ext_clock_out == ((s4 > 5'h19) ? 1'b0 : pins_d[s4]);
	endproperty
	a_t4_route: assert property (p_t4_route) else $error("timer4 clock routing wrong");
	property p_sel_unused;
		(timer_clock_input_select_out & 16'hE0E0) == 16'h0000;
	endproperty
	a_sel_unused: assert property (p_sel_unused) else $error("unused select bits set");
endmodule // rlcis_top_checker
bind rlcis_top rlcis_top_checker #(.NUM_REMAP(NUM_REMAP), .NUM_PINS(NUM_PINS)) i_rlcis_top_checker (.*);

// ### verif/rlcis_top_tb_top.sv
// Self-checking bench for the remap lock block over its register port.
// Assumes strobes one cycle long and read data in the cycle after the read.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module rlcis_top_tb_top;
	reg sys_clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg clk_en_in = 1'b1;
	reg single_session_cfg_in = 1'b0;
	reg [3:0] addr_in = 4'h0;
	reg [15:0] wdata_in = 16'h0000;
	reg wr_in = 1'b0;
	reg rd_in = 1'b0;
	reg [25:0] remappable_pin_n_in = 26'h0000000;
	wire [15:0] rdata_out;
	wire remap_lock_out;
	wire cfg_mismatch_reset_out;
	wire [15:0] timer_clock_input_select_out;
	wire timer5_ext_clock_out;
	wire timer4_ext_clock_out;
	wire [63:0] remap_regs_out;
	int errors = 0;
	int compares = 0;
	reg [4:0] c4;
	reg [4:0] c5;
	always #5 sys_clk_in = ~sys_clk_in;
	rlcis_top i_rlcis_top (.*);
	task end_of_test;
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task do_reset(input reg s);
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		single_session_cfg_in <= s;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
	endtask
	// Leaves the strobe up so key writes can run back to back
	task wr(input reg [3:0] a, input reg [15:0] d);
		@(posedge sys_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
	endtask
	task idle;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input reg [3:0] a, input reg [15:0] e, input reg [15:0] m);
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1;
		`CHK("rdata", e, rdata_out & m)
	endtask
	task lockseq(input reg [15:0] v);
		wr(4'h0, 16'h0046);
		wr(4'h0, 16'h0057);
		wr(4'h0, v);
		idle;
	endtask
	task chk_lock(input reg e);
		repeat (2) @(posedge sys_clk_in);
		#1;
		`CHK("lock", e, remap_lock_out)
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		end_of_test;
	end
	initial begin
		do_reset(1'b0);
		rd(4'h1, 16'h1F1F, 16'hFFFF);
		rd(4'hF, 16'h0000, 16'hFFFF);
		wr(4'h1, 16'hFFFF);
		idle;
		rd(4'h1, 16'h1F1F, 16'hFFFF);
		for (int i = 0; i < 32; i++) begin
			c4 = i;
			c5 = ~c4;
			wr(4'h1, {3'h0, c5, 3'h0, c4});
			idle;
			remappable_pin_n_in <= {26{c4[1]}} ^ 26'h2AAAAAA;
			repeat (3) @(posedge sys_clk_in);
			#1;
			`CHK("t4clk", (c4 > 5'h19) ? 1'b0 : remappable_pin_n_in[c4], timer4_ext_clock_out)
			`CHK("t5clk", (c5 > 5'h19) ? 1'b0 : remappable_pin_n_in[c5], timer5_ext_clock_out)
		end
		`CHK("selout", 16'h001F, timer_clock_input_select_out)
		wr(4'h8, 16'h1234);
		idle;
		lockseq(16'h0040);
		chk_lock(1'b1);
		rd(4'h0, 16'h0040, 16'h0040);
		wr(4'h8, 16'hBEEF);
		wr(4'h1, 16'h0000);
		idle;
		rd(4'h8, 16'h1234, 16'hFFFF);
		rd(4'h1, 16'h001F, 16'hFFFF);
		`CHK("remapout", 16'h1234, remap_regs_out[15:0])
		`CHK("cfgrst", 1'b0, cfg_mismatch_reset_out)
		// Foreign write between keys must kill the sequence
		wr(4'h0, 16'h0046);
		wr(4'h2, 16'h0000);
		wr(4'h0, 16'h0057);
		wr(4'h0, 16'h0000);
		idle;
		chk_lock(1'b1);
		lockseq(16'h0000);
		chk_lock(1'b0);
		wr(4'h9, 16'h5555);
		wr(4'h8, 16'hAAAA);
		idle;
		rd(4'h9, 16'h5555, 16'hFFFF);
		rd(4'h8, 16'hAAAA, 16'hFFFF);
		`CHK("remapout", 16'h5555, remap_regs_out[31:16])
		do_reset(1'b1);
		rd(4'h2, 16'h0001, 16'h0001);
		lockseq(16'h0040);
		lockseq(16'h0000);
		chk_lock(1'b1);
		wr(4'h8, 16'h0BAD);
		idle;
		rd(4'h8, 16'h0000, 16'hFFFF);
		do_reset(1'b1);
		chk_lock(1'b0);
		wr(4'h8, 16'h00C3);
		idle;
		rd(4'h8, 16'h00C3, 16'hFFFF);
		// Frozen clock enable must swallow the write
		@(posedge sys_clk_in);
		clk_en_in <= 1'b0;
		wr(4'h8, 16'h0077);
		idle;
		@(posedge sys_clk_in);
		clk_en_in <= 1'b1;
		rd(4'h8, 16'h00C3, 16'hFFFF);
		end_of_test;
	end
endmodule // rlcis_top_tb_top
